// file: logic/rsl_defs.svh
// Constants for the ring segment link walker
// Assumes 64-bit descriptor addresses and 16-byte ring descriptors
`ifndef RSL_DEFS_SVH
`define RSL_DEFS_SVH
`define RSL_DESC_BYTES      16
`define RSL_ADDR_W          64
`define RSL_TYPE_W          6
`define RSL_TYPE_LINK       6'h06
`define RSL_TYPE_NOOP_CMD   6'h17
`define RSL_TYPE_NEG_BW     6'h15
`define RSL_TYPE_SET_LTV    6'h16
`define RSL_CC_SUCCESS      8'h01
`define RSL_CC_TRB_ERROR    8'h05
`define RSL_PRIMARY_INTR    10'h000
`define RSL_ZERO_SLOT       8'h00
`define RSL_ZERO_VF         8'h00
`define RSL_ZERO_LEN        24'h000000
`endif

// file: logic/rsl_pkg.sv
// Types for the ring segment link walker
// Assumes rsl_defs.svh sits on the include path
package rsl_pkg;
    // One descriptor as fetched from memory, decoded fields only
    typedef struct packed {
        logic [63:0] ptr;
        logic [5:0]  dtype;
        logic        cycle;
        logic        chain;
        logic        notify;
        logic        toggle;
        logic [9:0]  intr;
        logic [23:0] len;
    } rsl_desc_s;
    // Completion event handed to the event poster
    typedef struct packed {
        logic        is_cmd;
        logic [63:0] ptr;
        logic [7:0]  slot;
        logic [4:0]  ep;
        logic [7:0]  vf;
        logic [23:0] len;
        logic [7:0]  code;
        logic [9:0]  intr;
    } rsl_event_s;
    typedef enum logic [1:0] {
        RSL_KIND_XFER,
        RSL_KIND_LINK,
        RSL_KIND_CMD,
        RSL_KIND_SKIP
    } rsl_kind_e;
endpackage

// file: logic/rsl_link_decode.sv
// Classifies a fetched descriptor for the ring walker
// Assumes the capability bits are static straps
`timescale 1ns/1ps
`include "rsl_defs.svh"
module rsl_link_decode
    import rsl_pkg::*;
(
    input  wire rsl_desc_s desc_in,
    input  wire logic      is_cmd_ring_in,
    input  wire logic      bw_capable_in,
    input  wire logic      lt_capable_in,
    output rsl_kind_e      kind_out,
    output logic           unsupported_out
);
    // ****************************************
    // Decode
    // ****************************************
    always_comb begin
        unsupported_out = 1'b0;
        if (desc_in.dtype == `RSL_TYPE_LINK) begin
            kind_out = RSL_KIND_LINK;
        end else if (is_cmd_ring_in) begin
            kind_out = RSL_KIND_CMD;
            if (desc_in.dtype == `RSL_TYPE_NEG_BW && !bw_capable_in) begin
                unsupported_out = 1'b1;
            end
            if (desc_in.dtype == `RSL_TYPE_SET_LTV && !lt_capable_in) begin
                unsupported_out = 1'b1;
            end
        end else begin
            kind_out = RSL_KIND_XFER;
        end
    end
endmodule

// file: logic/rsl_ring_walker.sv
// Ring segment link walker: dequeue side of one transfer or command ring
// Assumes a memory reader that answers one descriptor per request
// Operation
// - Link entry segment pointer becomes next fetch address.
// - Link pointers need not be page aligned; any aligned target accepted.
// - Transfer-ring link leads to first descriptor of next segment.
// - Chained group before a link continues into next segment.
// - Command ring ignores link chain flag.
// - Transfer link with notify posts transfer event, length zero, success.
// - Command link with notify posts completion, slot zero, vf zero, success.
// - Command completions go to interrupter zero; link target ignored.
// - Controller may fetch owned descriptors in bursts, any order.
// - Negotiate-bandwidth command only when bandwidth capability set.
// - Latency-tolerance command only when latency capability set.
`timescale 1ns/1ps
`include "rsl_defs.svh"
module rsl_ring_walker
    import rsl_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    input  wire logic        clk_en_in,
    input  wire logic        is_cmd_ring_in,
    input  wire logic        bw_capable_in,
    input  wire logic        lt_capable_in,
    input  wire logic [7:0]  slot_id_in,
    input  wire logic [4:0]  ep_id_in,
    input  wire logic        start_in,
    input  wire logic [63:0] start_ptr_in,
    input  wire logic        start_cycle_in,
    output logic             fetch_req_out,
    output logic [63:0]      fetch_addr_out,
    input  wire logic        fetch_ack_in,
    input  wire rsl_desc_s   fetch_desc_in,
    output logic             exec_valid_out,
    output rsl_desc_s        exec_desc_out,
    output logic             exec_continue_out,
    output logic             exec_unsupported_out,
    input  wire logic        exec_ready_in,
    output logic             evt_valid_out,
    output rsl_event_s       evt_out,
    input  wire logic        evt_ready_in,
    output logic [63:0]      dequeue_ptr_out,
    output logic             consumer_cycle_out,
    output logic             idle_out
);
    typedef enum logic [2:0] {
        RSL_IDLE,
        RSL_FETCH,
        RSL_DECIDE,
        RSL_EXEC,
        RSL_EVENT
    } rsl_state_e;

    rsl_state_e  state_ff;
    rsl_state_e  nxt_state;
    logic [63:0] deq_ff;
    logic        ccs_ff;
    logic        chain_ff;
    rsl_desc_s   desc_ff;
    rsl_event_s  evt_ff;
    rsl_kind_e   kind;
    logic        unsupported;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [63:0] next_slot(input logic [63:0] a);
        next_slot = a + 64'(`RSL_DESC_BYTES);
    endfunction

    function automatic logic [63:0] desc_align(input logic [63:0] a);
        desc_align = {a[63:4], 4'h0};
    endfunction

    rsl_link_decode u_decode (
        .desc_in         (desc_ff),
        .is_cmd_ring_in  (is_cmd_ring_in),
        .bw_capable_in   (bw_capable_in),
        .lt_capable_in   (lt_capable_in),
        .kind_out        (kind),
        .unsupported_out (unsupported)
    );

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            RSL_IDLE: begin
                if (start_in) begin
                    nxt_state = RSL_FETCH;
                end
            end
            RSL_FETCH: begin
                if (fetch_ack_in) begin
                    nxt_state = RSL_DECIDE;
                end
            end
            RSL_DECIDE: begin
                if (desc_ff.cycle != ccs_ff) begin
                    nxt_state = RSL_IDLE;
                end else if (kind == RSL_KIND_LINK) begin
                    nxt_state = desc_ff.notify ? RSL_EVENT : RSL_FETCH;
                end else begin
                    nxt_state = RSL_EXEC;
                end
            end
            RSL_EXEC: begin
                if (exec_ready_in) begin
                    nxt_state = RSL_FETCH;
                end
            end
            RSL_EVENT: begin
                if (evt_ready_in) begin
                    nxt_state = RSL_FETCH;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            state_ff <= RSL_IDLE;
        end else if (clk_en_in) begin
            state_ff <= nxt_state;
        end
    end

    // ****************************************
    // Fetch capture
    // ****************************************
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            desc_ff <= '0;
        end else if (clk_en_in && state_ff == RSL_FETCH && fetch_ack_in) begin
            desc_ff <= fetch_desc_in;
        end
    end

    // ****************************************
    // Dequeue pointer and cycle state
    // ****************************************
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            deq_ff <= 64'h0;
            ccs_ff <= 1'b0;
        end else if (clk_en_in) begin
            if (state_ff == RSL_IDLE && start_in) begin
                deq_ff <= desc_align(start_ptr_in);
                ccs_ff <= start_cycle_in;
            end else if (state_ff == RSL_DECIDE && desc_ff.cycle == ccs_ff && kind == RSL_KIND_LINK) begin
                // Any aligned target, page start not required
                deq_ff <= desc_align(desc_ff.ptr);
                if (desc_ff.toggle) begin
                    ccs_ff <= ~ccs_ff;
                end
            end else if (state_ff == RSL_EXEC && exec_ready_in) begin
                deq_ff <= next_slot(deq_ff);
            end
        end
    end

    // ****************************************
    // Chain tracking across segments
    // ****************************************
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            chain_ff <= 1'b0;
        end else if (clk_en_in) begin
            if (state_ff == RSL_IDLE && start_in) begin
                chain_ff <= 1'b0;
            end else if (state_ff == RSL_EXEC && exec_ready_in) begin
                // Link entries leave the flag alone so a group spans segments
                chain_ff <= is_cmd_ring_in ? 1'b0 : exec_desc_out.chain;
            end
        end
    end

    // ****************************************
    // Event build
    // ****************************************
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            evt_ff <= '0;
        end else if (clk_en_in && state_ff == RSL_DECIDE && kind == RSL_KIND_LINK) begin
            evt_ff.is_cmd <= is_cmd_ring_in;
            evt_ff.ptr    <= deq_ff;
            evt_ff.code   <= `RSL_CC_SUCCESS;
            evt_ff.len    <= `RSL_ZERO_LEN;
            if (is_cmd_ring_in) begin
                evt_ff.slot <= `RSL_ZERO_SLOT;
                evt_ff.ep   <= 5'h00;
                evt_ff.vf   <= `RSL_ZERO_VF;
                evt_ff.intr <= `RSL_PRIMARY_INTR;
            end else begin
                evt_ff.slot <= slot_id_in;
                evt_ff.ep   <= ep_id_in;
                evt_ff.vf   <= `RSL_ZERO_VF;
                evt_ff.intr <= desc_ff.intr;
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // One descriptor per request; bursts left to the memory reader
    assign fetch_req_out        = (state_ff == RSL_FETCH);
    assign fetch_addr_out       = deq_ff;
    assign exec_valid_out       = (state_ff == RSL_EXEC);
    assign exec_desc_out        = desc_ff;
    assign exec_continue_out    = chain_ff;
    assign exec_unsupported_out = unsupported;
    assign evt_valid_out        = (state_ff == RSL_EVENT);
    assign evt_out              = evt_ff;
    assign dequeue_ptr_out      = deq_ff;
    assign consumer_cycle_out   = ccs_ff;
    assign idle_out             = (state_ff == RSL_IDLE);

    // ****************************************
    // Checks
    // ****************************************
    property p_link_follow;
        @(posedge clk_sys_in) disable iff (rst_in)
        (clk_en_in && state_ff == RSL_DECIDE && kind == RSL_KIND_LINK && desc_ff.cycle == ccs_ff)
        |=> (deq_ff == desc_align($past(desc_ff.ptr)));
    endproperty
    a_link_follow: assert property (p_link_follow) else $error("link pointer not followed");

    property p_toggle;
        @(posedge clk_sys_in) disable iff (rst_in)
        (clk_en_in && state_ff == RSL_DECIDE && kind == RSL_KIND_LINK && desc_ff.cycle == ccs_ff)
        |=> (ccs_ff == ($past(ccs_ff) ^ $past(desc_ff.toggle)));
    endproperty
    a_toggle: assert property (p_toggle) else $error("cycle state toggle wrong");

    property p_stale_stop;
        @(posedge clk_sys_in) disable iff (rst_in)
        (clk_en_in && state_ff == RSL_DECIDE && desc_ff.cycle != ccs_ff) |=> idle_out;
    endproperty
    a_stale_stop: assert property (p_stale_stop) else $error("stale descriptor consumed");

    property p_xfer_evt;
        @(posedge clk_sys_in) disable iff (rst_in)
        (evt_valid_out && !evt_out.is_cmd) |-> (evt_out.len == 24'h0 && evt_out.code == 8'h01
            && evt_out.slot == slot_id_in && evt_out.ep == ep_id_in);
    endproperty
    a_xfer_evt: assert property (p_xfer_evt) else $error("transfer link event fields wrong");

    property p_cmd_evt;
        @(posedge clk_sys_in) disable iff (rst_in)
        (evt_valid_out && evt_out.is_cmd) |-> (evt_out.slot == 8'h0 && evt_out.vf == 8'h0 && evt_out.code == 8'h01);
    endproperty
    a_cmd_evt: assert property (p_cmd_evt) else $error("command link event fields wrong");

    property p_cmd_intr;
        @(posedge clk_sys_in) disable iff (rst_in)
        (evt_valid_out && evt_out.is_cmd) |-> (evt_out.intr == 10'h0);
    endproperty
    a_cmd_intr: assert property (p_cmd_intr) else $error("command event not on interrupter zero");

    property p_chain_cmd;
        @(posedge clk_sys_in) disable iff (rst_in)
        is_cmd_ring_in && exec_valid_out |-> !exec_continue_out;
    endproperty
    a_chain_cmd: assert property (p_chain_cmd) else $error("chain honoured on command ring");

    property p_chain_span;
        @(posedge clk_sys_in) disable iff (rst_in)
        (clk_en_in && state_ff == RSL_DECIDE && kind == RSL_KIND_LINK) |=> $stable(chain_ff);
    endproperty
    a_chain_span: assert property (p_chain_span) else $error("chain lost across link");

    property p_bw_gate;
        @(posedge clk_sys_in) disable iff (rst_in)
        (exec_valid_out && is_cmd_ring_in && desc_ff.dtype == 6'h15) |-> (exec_unsupported_out == !bw_capable_in);
    endproperty
    a_bw_gate: assert property (p_bw_gate) else $error("bandwidth command gating wrong");

    property p_lt_gate;
        @(posedge clk_sys_in) disable iff (rst_in)
        (exec_valid_out && is_cmd_ring_in && desc_ff.dtype == 6'h16) |-> (exec_unsupported_out == !lt_capable_in);
    endproperty
    a_lt_gate: assert property (p_lt_gate) else $error("latency command gating wrong");

    property p_chain_carry;
        @(posedge clk_sys_in) disable iff (rst_in)
        (clk_en_in && exec_valid_out && exec_ready_in && !is_cmd_ring_in)
        |=> (exec_continue_out == $past(exec_desc_out.chain));
    endproperty
    a_chain_carry: assert property (p_chain_carry) else $error("chain flag not carried");

    property p_plain_link;
        @(posedge clk_sys_in) disable iff (rst_in)
        (clk_en_in && state_ff == RSL_DECIDE && kind == RSL_KIND_LINK && desc_ff.cycle == ccs_ff && !desc_ff.notify)
        |=> fetch_req_out;
    endproperty
    a_plain_link: assert property (p_plain_link) else $error("plain link did not refetch");
endmodule

// file: dv/rsl_mem_model.sv
// Descriptor memory standing in for the software that builds the rings
// Assumes one outstanding fetch, answered lat_in plus one cycles after the request
`timescale 1ns/1ps
`include "rsl_defs.svh"
module rsl_mem_model
    import rsl_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    input  wire logic [3:0]  lat_in,
    input  wire logic        fetch_req_in,
    input  wire logic [63:0] fetch_addr_in,
    output logic             fetch_ack_out,
    output rsl_desc_s        fetch_desc_out
);
    // ****************************************
    // Ring storage, 256 descriptor slots
    // ****************************************
    rsl_desc_s  mem [256];
    logic [3:0] wait_ff;

    // ****************************************
    // Fetch answer, data garbled outside the ack
    // ****************************************
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            wait_ff        <= 4'h0;
            fetch_ack_out  <= 1'b0;
            fetch_desc_out <= '0;
        end else if (fetch_req_in && !fetch_ack_out && wait_ff == lat_in) begin
            wait_ff        <= 4'h0;
            fetch_ack_out  <= 1'b1;
            fetch_desc_out <= mem[fetch_addr_in[11:4]];
        end else begin
            wait_ff        <= (fetch_req_in && !fetch_ack_out) ? wait_ff + 4'h1 : 4'h0;
            fetch_ack_out  <= 1'b0;
            fetch_desc_out <= ~fetch_desc_out;
        end
    end
endmodule

// file: dv/tb.sv
// Self-checking bench for the ring segment link walker
// Assumes the design headers on the include path and a 125 MHz clock
`timescale 1ns/1ps
`include "rsl_defs.svh"
module tb;
    import rsl_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic        clk_sys_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        is_cmd_ring_in = 1'b0, bw_capable_in = 1'b0, lt_capable_in = 1'b0;
    logic        start_in = 1'b0, start_cycle_in = 1'b0, exec_ready_in = 1'b0, evt_ready_in = 1'b0;
    logic [7:0]  slot_id_in = 8'h2a;
    logic [4:0]  ep_id_in = 5'h03;
    logic [3:0]  lat = 4'h2;
    logic        clk_en = 1'b1;
    logic [63:0] start_ptr_in = 64'h0;
    logic        fetch_req_out, fetch_ack_in, exec_valid_out, exec_continue_out, exec_unsupported_out;
    logic        evt_valid_out, consumer_cycle_out, idle_out;
    logic [63:0] fetch_addr_out, dequeue_ptr_out;
    rsl_desc_s   fetch_desc_in, exec_desc_out;
    rsl_event_s  evt_out;
    int          n_errors = 0;
    int          compares = 0;

    initial begin
        forever #4 clk_sys_in = ~clk_sys_in;
    end

    rsl_ring_walker rsl_ring_walker_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .clk_en_in(clk_en),
        .is_cmd_ring_in(is_cmd_ring_in), .bw_capable_in(bw_capable_in), .lt_capable_in(lt_capable_in),
        .slot_id_in(slot_id_in), .ep_id_in(ep_id_in), .start_in(start_in), .start_ptr_in(start_ptr_in),
        .start_cycle_in(start_cycle_in), .fetch_req_out(fetch_req_out), .fetch_addr_out(fetch_addr_out),
        .fetch_ack_in(fetch_ack_in), .fetch_desc_in(fetch_desc_in), .exec_valid_out(exec_valid_out),
        .exec_desc_out(exec_desc_out), .exec_continue_out(exec_continue_out),
        .exec_unsupported_out(exec_unsupported_out), .exec_ready_in(exec_ready_in),
        .evt_valid_out(evt_valid_out), .evt_out(evt_out), .evt_ready_in(evt_ready_in),
        .dequeue_ptr_out(dequeue_ptr_out), .consumer_cycle_out(consumer_cycle_out), .idle_out(idle_out));

    rsl_mem_model rsl_mem_model_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .lat_in(lat),
        .fetch_req_in(fetch_req_out), .fetch_addr_in(fetch_addr_out), .fetch_ack_out(fetch_ack_in),
        .fetch_desc_out(fetch_desc_in));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        compares++;
        if (e !== g) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic put(input logic [63:0] a, input logic [5:0] t, input logic c, ch, nt, tg,
                       input logic [9:0] it, input logic [63:0] p);
        rsl_mem_model_i.mem[a[11:4]] = '{ptr: p, dtype: t, cycle: c, chain: ch, notify: nt, toggle: tg,
                                         intr: it, len: 24'h000000};
    endtask

    function automatic logic watched(input int w);
        watched = (w == 0) ? idle_out : (w == 1) ? exec_valid_out : evt_valid_out;
    endfunction

    task automatic await(input int w, input string nm);
        int k;
        k = 0;
        @(negedge clk_sys_in);
        while (watched(w) !== 1'b1 && k < 200) begin
            @(negedge clk_sys_in);
            k++;
        end
        if (k >= 200) chk(nm, 64'h1, 64'h0);
    endtask

    task automatic go(input logic [63:0] p, input logic c);
        await(0, "idle_before_start");
        @(posedge clk_sys_in);
        start_ptr_in   <= p;
        start_cycle_in <= c;
        start_in       <= 1'b1;
        @(posedge clk_sys_in) start_in <= 1'b0;
    endtask

    task automatic take_exec(input logic [63:0] a, input logic [5:0] t, input logic cont, uns);
        await(1, "exec_valid");
        chk("exec_ptr", a, dequeue_ptr_out);
        chk("exec_type", {58'h0, t}, {58'h0, exec_desc_out.dtype});
        chk("exec_continue", {63'h0, cont}, {63'h0, exec_continue_out});
        chk("exec_unsupported", {63'h0, uns}, {63'h0, exec_unsupported_out});
        @(posedge clk_sys_in);
        exec_ready_in <= 1'b1;
        clk_en        <= 1'b0;
        repeat (2) @(negedge clk_sys_in);
        chk("frozen_valid", 64'h1, {63'h0, exec_valid_out});
        chk("frozen_ptr", a, dequeue_ptr_out);
        @(posedge clk_sys_in) clk_en <= 1'b1;
        @(posedge clk_sys_in) exec_ready_in <= 1'b0;
    endtask

    task automatic take_evt(input logic cmd, input logic [63:0] p, input logic [7:0] sl, input logic [4:0] ep);
        await(2, "evt_valid");
        chk("evt_is_cmd", {63'h0, cmd}, {63'h0, evt_out.is_cmd});
        chk("evt_ptr", p, evt_out.ptr);
        chk("evt_slot", {56'h0, sl}, {56'h0, evt_out.slot});
        chk("evt_len", {40'h0, `RSL_ZERO_LEN}, {40'h0, evt_out.len});
        chk("evt_code", {56'h0, `RSL_CC_SUCCESS}, {56'h0, evt_out.code});
        if (cmd) begin
            chk("evt_vf", {56'h0, `RSL_ZERO_VF}, {56'h0, evt_out.vf});
            chk("evt_intr", {54'h0, `RSL_PRIMARY_INTR}, {54'h0, evt_out.intr});
        end else begin
            chk("evt_ep", {59'h0, ep}, {59'h0, evt_out.ep});
        end
        @(posedge clk_sys_in) evt_ready_in <= 1'b1;
        @(posedge clk_sys_in) evt_ready_in <= 1'b0;
    endtask

    task automatic settle(input logic [63:0] p, input logic c);
        await(0, "idle_after_ring");
        chk("dequeue_ptr", p, dequeue_ptr_out);
        chk("fetch_addr", p, fetch_addr_out);
        chk("consumer_cycle", {63'h0, c}, {63'h0, consumer_cycle_out});
    endtask

    task automatic cmd_pass(input logic bw, lt, input logic [3:0] l);
        @(posedge clk_sys_in);
        is_cmd_ring_in <= 1'b1;
        bw_capable_in  <= bw;
        lt_capable_in  <= lt;
        lat            <= l;
        put(64'h400, `RSL_TYPE_NEG_BW, 1'b0, 1'b0, 1'b0, 1'b0, 10'h0, 64'h0);
        put(64'h410, `RSL_TYPE_SET_LTV, 1'b0, 1'b1, 1'b0, 1'b0, 10'h0, 64'h0);
        put(64'h420, `RSL_TYPE_LINK, 1'b0, 1'b1, 1'b1, 1'b0, 10'h7, 64'h400);
        go(64'h400, 1'b0);
        take_exec(64'h400, `RSL_TYPE_NEG_BW, 1'b0, !bw);
        take_exec(64'h410, `RSL_TYPE_SET_LTV, 1'b0, !lt);
        take_evt(1'b1, 64'h420, `RSL_ZERO_SLOT, 5'h00);
        rsl_mem_model_i.mem[8'h41].cycle = 1'b1;
        take_exec(64'h400, `RSL_TYPE_NEG_BW, 1'b0, !bw);
        settle(64'h410, 1'b0);
        $display("test cmd_ring bw=%0b lt=%0b done", bw, lt);
    endtask

    task automatic wrap_up();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (4) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        put(64'h100, 6'h01, 1'b1, 1'b1, 1'b0, 1'b0, 10'h0, 64'h0);
        put(64'h110, `RSL_TYPE_LINK, 1'b1, 1'b1, 1'b0, 1'b0, 10'h0, 64'h2a0);
        put(64'h2a0, 6'h01, 1'b1, 1'b0, 1'b0, 1'b0, 10'h0, 64'h0);
        put(64'h2b0, `RSL_TYPE_LINK, 1'b1, 1'b0, 1'b1, 1'b1, 10'h3, 64'h100);
        go(64'h100, 1'b1);
        take_exec(64'h100, 6'h01, 1'b0, 1'b0);
        take_exec(64'h2a0, 6'h01, 1'b1, 1'b0);
        take_evt(1'b0, 64'h2b0, 8'h2a, 5'h03);
        settle(64'h100, 1'b0);
        $display("test xfer_ring done");
        cmd_pass(1'b0, 1'b1, 4'h0);
        cmd_pass(1'b1, 1'b0, 4'h3);
        wrap_up();
    end

    initial begin
        repeat (6000) @(posedge clk_sys_in);
        n_errors++;
        wrap_up();
    end
endmodule
